// *** voei_pkg.sv ***
// voei_pkg: constants and carrier types for the vector operation event increment block
// assumes the pipeline reports already classified operations, one record per lane
// Function
// - fixed float: elements or 1, doubled fused
// - scalable half float: 8, fused 16
// - fixed half float: 16-bit elements or 1, doubled
// - scalable single float: 4, fused 8
// - fixed single float: 32-bit elements or 1, doubled
// - scalable double float: 2, fused 4
// - fixed double float: 2 or 1, doubled
// - scalable integer: 128/container, fused doubled
// - fixed integer: elements or 1, multiply-accumulate doubled
// - scalable access: 128/container times registers, no replicate
// - fixed access: scalar, pair, atomic, replicate, structure
// - scalable read: 128/container times registers, no replicate
// - fixed read: scalar, pair, atomic, replicate, structure
// - scalable write: 128/container times registers
// - fixed write: scalar, pair, atomic, structure
// - scalable bytes: 16/(container/memory) times registers
package voei_pkg;

	// ==========================================
	// event codes of this group
	localparam logic [15:0] EV_FIXED_FLOAT    = 16'h80C1;
	localparam logic [15:0] EV_SCALE_BYTES    = 16'h80DA;

	// ==========================================
	// increment figures
	localparam int unsigned VEC_BITS     = 128; // granule width of a scalable vector
	localparam int unsigned VEC_BYTES    = 16;  // granule bytes
	localparam int unsigned HALF_INC     = 8;
	localparam int unsigned SINGLE_INC   = 4;
	localparam int unsigned DOUBLE_INC   = 2;
	localparam int unsigned FIXED_DBL    = 2;   // fixed double float vector elements
	localparam int unsigned SCALAR_INC   = 1;
	localparam int unsigned PAIR_INC     = 2;
	localparam int unsigned ATOM_ST_INC  = 1;
	localparam int unsigned ATOM_LD_BOTH = 2;   // atomic load in combined access count
	localparam int unsigned ATOM_LD_READ = 1;   // atomic load in read count
	localparam int unsigned REPL_EL_INC  = 1;

	// ==========================================
	// operation classes
	typedef enum logic [1:0] {VOEI_NONE, VOEI_FLOAT, VOEI_INT, VOEI_MEM} voei_class_t;
	typedef enum logic [1:0] {VOEI_PREC_HALF, VOEI_PREC_SINGLE, VOEI_PREC_DOUBLE,
		VOEI_PREC_OTHER} voei_prec_t;
	typedef enum logic [2:0] {VOEI_ACC_SCALAR, VOEI_ACC_PAIR, VOEI_ACC_ATOMIC,
		VOEI_ACC_REPL_EL, VOEI_ACC_REPL_QUAD, VOEI_ACC_STRUCT, VOEI_ACC_VECTOR}
		voei_access_t;

	// one classified operation from the pipeline
	typedef struct packed {
		logic         valid;      // record carries an operation
		voei_class_t  op_class;   // float, integer or memory
		logic         scalable;   // scalable vector form
		logic         vector;     // fixed-width vector form (else scalar)
		logic         fused;      // fused multiply-add / accumulate
		voei_prec_t   prec;       // float precision
		logic [7:0]   elements;   // fixed-width elements per vector
		logic [7:0]   cont_bits;  // container_bits: 8,16,32,64
		logic [7:0]   mem_bits;   // memory_element_bits: 8,16,32,64
		logic [2:0]   regs;       // vector registers transferred
		voei_access_t access;     // memory access shape
		logic         is_load;    // read (also set with is_store for atomics)
		logic         is_store;   // write
	} voei_op_t;

	// per-cycle increments, one field per event
	typedef struct packed {
		logic [15:0] fixed_float_element_ops;
		logic [15:0] scalable_half_float_ops;
		logic [15:0] fixed_half_float_ops;
		logic [15:0] scalable_single_float_ops;
		logic [15:0] fixed_single_float_ops;
		logic [15:0] scalable_double_float_ops;
		logic [15:0] fixed_double_float_ops;
		logic [15:0] scalable_integer_ops;
		logic [15:0] fixed_integer_ops;
		logic [15:0] scalable_memory_access_ops;
		logic [15:0] fixed_memory_access_ops;
		logic [15:0] scalable_read_ops;
		logic [15:0] fixed_read_ops;
		logic [15:0] scalable_write_ops;
		logic [15:0] fixed_write_ops;
		logic [15:0] scalable_memory_byte_count;
	} voei_inc_t;

	localparam int unsigned INC_W = 16;

endpackage : voei_pkg

// *** voei_top.sv ***
// voei_top: turns classified operations into per-event increments
// assumes the counter bank adds inc_ff every cycle; lanes are independent
`timescale 1ns/1ps
module voei_top #(
	parameter int unsigned LANES = 4
) (
	input  wire logic                       clk,      // core clock, 50 MHz
	input  wire logic                       rst_b,    // async reset, active low
	input  wire voei_pkg::voei_op_t [LANES-1:0] ops,  // operations this cycle
	output voei_pkg::voei_inc_t             inc_ff    // registered increments
);

	// ==========================================
	// elaboration checks
	if (LANES < 1 || LANES > 16) begin : g_lanes_range
		$error("voei_top: LANES must be 1 to 16");
	end

	// ==========================================
	// per-operation increment function
	function automatic voei_pkg::voei_inc_t op_inc(input voei_pkg::voei_op_t op);
		voei_pkg::voei_inc_t r;
		logic [15:0] gran;
		logic [15:0] fx;
		logic [15:0] regs;
		logic [15:0] bytes;
		logic [15:0] struct_n;
		logic [15:0] fixm;
		r = '0;
		gran = 16'h0000;
		if (op.cont_bits != 8'h00) begin
			gran = 16'(voei_pkg::VEC_BITS / int'(op.cont_bits));
		end
		regs = {13'h0000, op.regs};
		bytes = 16'h0000;
		if (op.cont_bits != 8'h00 && op.mem_bits != 8'h00 && op.cont_bits >= op.mem_bits) begin
			bytes = 16'(voei_pkg::VEC_BYTES / (int'(op.cont_bits) / int'(op.mem_bits)));
		end
		fx = op.vector ? {8'h00, op.elements} : 16'(voei_pkg::SCALAR_INC);
		if (!op.valid) begin
			return r;
		end
		case (op.op_class)
			voei_pkg::VOEI_FLOAT: begin
				if (op.scalable) begin
					case (op.prec)
						voei_pkg::VOEI_PREC_HALF: begin
							r.scalable_half_float_ops = 16'(voei_pkg::HALF_INC) << op.fused;
						end
						voei_pkg::VOEI_PREC_SINGLE: begin
							r.scalable_single_float_ops = 16'(voei_pkg::SINGLE_INC) << op.fused;
						end
						voei_pkg::VOEI_PREC_DOUBLE: begin
							r.scalable_double_float_ops = 16'(voei_pkg::DOUBLE_INC) << op.fused;
						end
						default: begin
						end
					endcase
				end else begin
					r.fixed_float_element_ops = fx << op.fused;
					case (op.prec)
						voei_pkg::VOEI_PREC_HALF: begin
							r.fixed_half_float_ops = fx << op.fused;
						end
						voei_pkg::VOEI_PREC_SINGLE: begin
							r.fixed_single_float_ops = fx << op.fused;
						end
						voei_pkg::VOEI_PREC_DOUBLE: begin
							fixm = op.vector ? 16'(voei_pkg::FIXED_DBL) : 16'(voei_pkg::SCALAR_INC);
							r.fixed_double_float_ops = fixm << op.fused;
						end
						default: begin
						end
					endcase
				end
			end
			voei_pkg::VOEI_INT: begin
				if (op.scalable) begin
					r.scalable_integer_ops = gran << op.fused;
				end else begin
					r.fixed_integer_ops = fx << op.fused;
				end
			end
			voei_pkg::VOEI_MEM: begin
				if (op.scalable) begin
					if (op.access == voei_pkg::VOEI_ACC_VECTOR) begin
						r.scalable_memory_access_ops = 16'(gran * regs);
						r.scalable_memory_byte_count = 16'(bytes * regs);
						if (op.is_load) begin
							r.scalable_read_ops = 16'(gran * regs);
						end
						if (op.is_store) begin
							r.scalable_write_ops = 16'(gran * regs);
						end
					end
				end
				if (!op.scalable || op.access == voei_pkg::VOEI_ACC_REPL_EL ||
					op.access == voei_pkg::VOEI_ACC_REPL_QUAD) begin
					struct_n = 16'({8'h00, op.elements} * regs);
					case (op.access)
						voei_pkg::VOEI_ACC_SCALAR: begin
							r.fixed_memory_access_ops = 16'(voei_pkg::SCALAR_INC);
							if (op.is_load) r.fixed_read_ops = 16'(voei_pkg::SCALAR_INC);
							if (op.is_store) r.fixed_write_ops = 16'(voei_pkg::SCALAR_INC);
						end
						voei_pkg::VOEI_ACC_PAIR: begin
							r.fixed_memory_access_ops = 16'(voei_pkg::PAIR_INC);
							if (op.is_load) r.fixed_read_ops = 16'(voei_pkg::PAIR_INC);
							if (op.is_store) r.fixed_write_ops = 16'(voei_pkg::PAIR_INC);
						end
						voei_pkg::VOEI_ACC_ATOMIC: begin
							// an atomic with a load counts as a load, else as a store
							if (op.is_load) begin
								r.fixed_memory_access_ops = 16'(voei_pkg::ATOM_LD_BOTH);
								r.fixed_read_ops = 16'(voei_pkg::ATOM_LD_READ);
							end else begin
								r.fixed_memory_access_ops = 16'(voei_pkg::ATOM_ST_INC);
								r.fixed_write_ops = 16'(voei_pkg::ATOM_ST_INC);
							end
						end
						voei_pkg::VOEI_ACC_REPL_EL: begin
							r.fixed_memory_access_ops = 16'(voei_pkg::REPL_EL_INC);
							r.fixed_read_ops = 16'(voei_pkg::REPL_EL_INC);
						end
						voei_pkg::VOEI_ACC_REPL_QUAD: begin
							r.fixed_memory_access_ops = gran;
							r.fixed_read_ops = gran;
						end
						voei_pkg::VOEI_ACC_STRUCT: begin
							r.fixed_memory_access_ops = struct_n;
							if (op.is_load) r.fixed_read_ops = struct_n;
							if (op.is_store) r.fixed_write_ops = struct_n;
						end
						default: begin
						end
					endcase
				end
			end
			default: begin
			end
		endcase
		return r;
	endfunction : op_inc

	// ==========================================
	// per-lane weighing: the same logic once for every lane
	voei_pkg::voei_inc_t lane_inc [LANES]; // increments of each lane on its own
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		// an idle or unclassified lane yields all-zero increments
		assign lane_inc[g] = op_inc(ops[g]);
	end

	// ==========================================
	// floating-point events, every lane summed in one cycle
	logic [15:0] nxt_fixed_float_element_ops;
	logic [15:0] nxt_scalable_half_float_ops;
	logic [15:0] nxt_fixed_half_float_ops;
	logic [15:0] nxt_scalable_single_float_ops;
	logic [15:0] nxt_fixed_single_float_ops;
	logic [15:0] nxt_scalable_double_float_ops;
	logic [15:0] nxt_fixed_double_float_ops;
	logic [15:0] fixed_float_element_ops_ff;
	logic [15:0] scalable_half_float_ops_ff;
	logic [15:0] fixed_half_float_ops_ff;
	logic [15:0] scalable_single_float_ops_ff;
	logic [15:0] fixed_single_float_ops_ff;
	logic [15:0] scalable_double_float_ops_ff;
	logic [15:0] fixed_double_float_ops_ff;
	// sums wrap at the field width, as the counter bank expects
	always_comb begin
		nxt_fixed_float_element_ops = 16'h0000;
		nxt_scalable_half_float_ops = 16'h0000;
		nxt_fixed_half_float_ops = 16'h0000;
		nxt_scalable_single_float_ops = 16'h0000;
		nxt_fixed_single_float_ops = 16'h0000;
		nxt_scalable_double_float_ops = 16'h0000;
		nxt_fixed_double_float_ops = 16'h0000;
		for (int i = 0; i < LANES; i++) begin
			nxt_fixed_float_element_ops += lane_inc[i].fixed_float_element_ops;
			nxt_scalable_half_float_ops += lane_inc[i].scalable_half_float_ops;
			nxt_fixed_half_float_ops += lane_inc[i].fixed_half_float_ops;
			nxt_scalable_single_float_ops += lane_inc[i].scalable_single_float_ops;
			nxt_fixed_single_float_ops += lane_inc[i].fixed_single_float_ops;
			nxt_scalable_double_float_ops += lane_inc[i].scalable_double_float_ops;
			nxt_fixed_double_float_ops += lane_inc[i].fixed_double_float_ops;
		end
	end

	// floating-point increment registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fixed_float_element_ops_ff <= 16'h0000;
			scalable_half_float_ops_ff <= 16'h0000;
			fixed_half_float_ops_ff <= 16'h0000;
			scalable_single_float_ops_ff <= 16'h0000;
			fixed_single_float_ops_ff <= 16'h0000;
			scalable_double_float_ops_ff <= 16'h0000;
			fixed_double_float_ops_ff <= 16'h0000;
		end else begin
			fixed_float_element_ops_ff <= nxt_fixed_float_element_ops;
			scalable_half_float_ops_ff <= nxt_scalable_half_float_ops;
			fixed_half_float_ops_ff <= nxt_fixed_half_float_ops;
			scalable_single_float_ops_ff <= nxt_scalable_single_float_ops;
			fixed_single_float_ops_ff <= nxt_fixed_single_float_ops;
			scalable_double_float_ops_ff <= nxt_scalable_double_float_ops;
			fixed_double_float_ops_ff <= nxt_fixed_double_float_ops;
		end
	end

	// ==========================================
	// integer events, every lane summed in one cycle
	logic [15:0] nxt_scalable_integer_ops;
	logic [15:0] nxt_fixed_integer_ops;
	logic [15:0] scalable_integer_ops_ff;
	logic [15:0] fixed_integer_ops_ff;
	// sums wrap at the field width
	always_comb begin
		nxt_scalable_integer_ops = 16'h0000;
		nxt_fixed_integer_ops = 16'h0000;
		for (int i = 0; i < LANES; i++) begin
			nxt_scalable_integer_ops += lane_inc[i].scalable_integer_ops;
			nxt_fixed_integer_ops += lane_inc[i].fixed_integer_ops;
		end
	end

	// integer increment registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scalable_integer_ops_ff <= 16'h0000;
			fixed_integer_ops_ff <= 16'h0000;
		end else begin
			scalable_integer_ops_ff <= nxt_scalable_integer_ops;
			fixed_integer_ops_ff <= nxt_fixed_integer_ops;
		end
	end

	// ==========================================
	// memory access events, every lane summed in one cycle
	logic [15:0] nxt_scalable_memory_access_ops;
	logic [15:0] nxt_fixed_memory_access_ops;
	logic [15:0] nxt_scalable_read_ops;
	logic [15:0] nxt_fixed_read_ops;
	logic [15:0] nxt_scalable_write_ops;
	logic [15:0] nxt_fixed_write_ops;
	logic [15:0] nxt_scalable_memory_byte_count;
	logic [15:0] scalable_memory_access_ops_ff;
	logic [15:0] fixed_memory_access_ops_ff;
	logic [15:0] scalable_read_ops_ff;
	logic [15:0] fixed_read_ops_ff;
	logic [15:0] scalable_write_ops_ff;
	logic [15:0] fixed_write_ops_ff;
	logic [15:0] scalable_memory_byte_count_ff;
	// sums wrap at the field width
	always_comb begin
		nxt_scalable_memory_access_ops = 16'h0000;
		nxt_fixed_memory_access_ops = 16'h0000;
		nxt_scalable_read_ops = 16'h0000;
		nxt_fixed_read_ops = 16'h0000;
		nxt_scalable_write_ops = 16'h0000;
		nxt_fixed_write_ops = 16'h0000;
		nxt_scalable_memory_byte_count = 16'h0000;
		for (int i = 0; i < LANES; i++) begin
			nxt_scalable_memory_access_ops += lane_inc[i].scalable_memory_access_ops;
			nxt_fixed_memory_access_ops += lane_inc[i].fixed_memory_access_ops;
			nxt_scalable_read_ops += lane_inc[i].scalable_read_ops;
			nxt_fixed_read_ops += lane_inc[i].fixed_read_ops;
			nxt_scalable_write_ops += lane_inc[i].scalable_write_ops;
			nxt_fixed_write_ops += lane_inc[i].fixed_write_ops;
			nxt_scalable_memory_byte_count += lane_inc[i].scalable_memory_byte_count;
		end
	end

	// memory access increment registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scalable_memory_access_ops_ff <= 16'h0000;
			fixed_memory_access_ops_ff <= 16'h0000;
			scalable_read_ops_ff <= 16'h0000;
			fixed_read_ops_ff <= 16'h0000;
			scalable_write_ops_ff <= 16'h0000;
			fixed_write_ops_ff <= 16'h0000;
			scalable_memory_byte_count_ff <= 16'h0000;
		end else begin
			scalable_memory_access_ops_ff <= nxt_scalable_memory_access_ops;
			fixed_memory_access_ops_ff <= nxt_fixed_memory_access_ops;
			scalable_read_ops_ff <= nxt_scalable_read_ops;
			fixed_read_ops_ff <= nxt_fixed_read_ops;
			scalable_write_ops_ff <= nxt_scalable_write_ops;
			fixed_write_ops_ff <= nxt_fixed_write_ops;
			scalable_memory_byte_count_ff <= nxt_scalable_memory_byte_count;
		end
	end

	// ==========================================
	// output record gathered from the per-event registers, wiring only
	always_comb begin
		inc_ff.fixed_float_element_ops = fixed_float_element_ops_ff;
		inc_ff.scalable_half_float_ops = scalable_half_float_ops_ff;
		inc_ff.fixed_half_float_ops = fixed_half_float_ops_ff;
		inc_ff.scalable_single_float_ops = scalable_single_float_ops_ff;
		inc_ff.fixed_single_float_ops = fixed_single_float_ops_ff;
		inc_ff.scalable_double_float_ops = scalable_double_float_ops_ff;
		inc_ff.fixed_double_float_ops = fixed_double_float_ops_ff;
		inc_ff.scalable_integer_ops = scalable_integer_ops_ff;
		inc_ff.fixed_integer_ops = fixed_integer_ops_ff;
		inc_ff.scalable_memory_access_ops = scalable_memory_access_ops_ff;
		inc_ff.fixed_memory_access_ops = fixed_memory_access_ops_ff;
		inc_ff.scalable_read_ops = scalable_read_ops_ff;
		inc_ff.fixed_read_ops = fixed_read_ops_ff;
		inc_ff.scalable_write_ops = scalable_write_ops_ff;
		inc_ff.fixed_write_ops = fixed_write_ops_ff;
		inc_ff.scalable_memory_byte_count = scalable_memory_byte_count_ff;
	end

endmodule : voei_top

// *** voei_top_sva.sv ***
// voei_top_sva: port-level assertions for the event increment block
// assumes the voei_pkg package is compiled first; bound into voei_top
`timescale 1ns/1ps
module voei_top_sva #(
	parameter int unsigned LANES = 4
) (
	input wire logic                            clk,    // core clock
	input wire logic                            rst_b,  // async reset, active low
	input wire voei_pkg::voei_op_t [LANES-1:0]  ops,    // operations in
	input wire voei_pkg::voei_inc_t             inc_ff  // increments out
);
	logic rest_idle;
	logic solo;
	// ==========================================
	// lane 0 alone carries an operation
	always_comb begin
		rest_idle = 1'b1;
		for (int i = 1; i < LANES; i++) if (ops[i].valid) rest_idle = 1'b0;
		solo = rest_idle && ops[0].valid;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_kind(c, s);
		solo && ops[0].op_class == c && ops[0].scalable == s;
	endsequence
	property p_sfp(p, fld, v);
		s_kind(voei_pkg::VOEI_FLOAT, 1'b1) ##0 ops[0].prec == p
			|=> fld == (16'(v) << $past(ops[0].fused));
	endproperty
	// ==========================================
	// assertions
	a_reset_clear: assert property (disable iff (1'b0) !rst_b |-> inc_ff == '0)
		else $error("increments not zero in reset");
	a_idle_zero: assert property (rest_idle && !ops[0].valid |=> inc_ff == '0)
		else $error("increment without operation");
	a_half_scale: assert property (p_sfp(voei_pkg::VOEI_PREC_HALF,
		inc_ff.scalable_half_float_ops, 8)) else $error("scalable half increment wrong");
	a_single_scale: assert property (p_sfp(voei_pkg::VOEI_PREC_SINGLE,
		inc_ff.scalable_single_float_ops, 4)) else $error("scalable single increment wrong");
	a_double_scale: assert property (p_sfp(voei_pkg::VOEI_PREC_DOUBLE,
		inc_ff.scalable_double_float_ops, 2)) else $error("scalable double increment wrong");
	a_scale_not_fixed: assert property (s_kind(voei_pkg::VOEI_FLOAT, 1'b1)
		|=> inc_ff.fixed_float_element_ops == '0) else $error("scalable float in fixed");
	a_fixed_double: assert property (s_kind(voei_pkg::VOEI_FLOAT, 1'b0) ##0
		ops[0].prec == voei_pkg::VOEI_PREC_DOUBLE |=> inc_ff.fixed_double_float_ops ==
		(($past(ops[0].vector) ? 16'h0002 : 16'h0001) << $past(ops[0].fused)))
		else $error("fixed double increment wrong");
	a_repl_excluded: assert property (s_kind(voei_pkg::VOEI_MEM, 1'b1) ##0
		ops[0].access != voei_pkg::VOEI_ACC_VECTOR |=> inc_ff.scalable_memory_access_ops
		== '0 && inc_ff.scalable_memory_byte_count == '0) else $error("replicate counted");
endmodule : voei_top_sva
bind voei_top voei_top_sva #(.LANES(LANES)) i_voei_top_sva (.clk(clk), .rst_b(rst_b),
	.ops(ops), .inc_ff(inc_ff));

// *** voei_pipe_model.sv ***
// voei_pipe_model: execution pipeline reporting classified operations
// assumes the bench picks random or directed records; changes at falling edge
`timescale 1ns/1ps
module voei_pipe_model #(
	parameter int unsigned LANES = 4
) (
	input  wire logic                           clk,   // core clock
	input  wire logic                           rnd,   // random records when high
	input  wire voei_pkg::voei_op_t [LANES-1:0] pick,  // directed records
	output voei_pkg::voei_op_t [LANES-1:0]      ops    // records to the block
);
	int seed = 98;
	// ==========================================
	// random record kept within legal field values
	function automatic voei_pkg::voei_op_t rand_op();
		voei_pkg::voei_op_t o;
		logic [63:0]        w;
		w = {$random(seed), $random(seed)};
		o = w[$bits(voei_pkg::voei_op_t)-1:0]; // keep the record's width of random bits
		o.cont_bits = 8'h08 << o.cont_bits[1:0];
		o.mem_bits = 8'h08 << o.mem_bits[1:0];
		o.elements = {4'h0, o.elements[3:0]} + 8'h01;
		o.regs = {1'b0, o.regs[1:0]} + 3'h1;
		o.is_store = !o.is_load;
		if (o.scalable) o.access = o.access[0] ? voei_pkg::VOEI_ACC_VECTOR :
			(o.access[1] ? voei_pkg::VOEI_ACC_REPL_EL : voei_pkg::VOEI_ACC_REPL_QUAD);
		else if (o.access > voei_pkg::VOEI_ACC_STRUCT) o.access = voei_pkg::VOEI_ACC_SCALAR;
		if (o.access inside {voei_pkg::VOEI_ACC_REPL_EL, voei_pkg::VOEI_ACC_REPL_QUAD})
			{o.is_load, o.is_store} = 2'h2;
		return o;
	endfunction : rand_op
	initial ops = '0;
	// new records each falling edge
	always @(negedge clk) begin
		for (int i = 0; i < LANES; i++) ops[i] <= rnd ? rand_op() : pick[i];
	end
endmodule : voei_pipe_model

// *** vector_op_event_increment_tb.sv ***
// vector_op_event_increment_tb: self-checking bench for voei_top
// assumes voei_pkg, the pipeline model and the checker are compiled first
`timescale 1ns/1ps
module vector_op_event_increment_tb;
	localparam int unsigned LANES = 4;
	logic                          clk = 1'b0;
	logic                          rst_b = 1'b1;
	logic                          rnd = 1'b0;
	logic                          chk_en = 1'b0;
	voei_pkg::voei_op_t [LANES-1:0] pick = '0;
	voei_pkg::voei_op_t [LANES-1:0] ops;
	voei_pkg::voei_op_t            o;
	voei_pkg::voei_inc_t           inc_ff;
	voei_pkg::voei_inc_t           exp_q = '0;
	voei_pkg::voei_inc_t           lane_exp;
	int                            miscompares = 0;
	int                            n_tests = 0;
	initial forever #10 clk = ~clk;
	voei_top #(.LANES(LANES)) i_voei_top (.clk(clk), .rst_b(rst_b), .ops(ops), .inc_ff(inc_ff));
	voei_pipe_model #(.LANES(LANES)) i_voei_pipe_model (.clk(clk), .rnd(rnd), .pick(pick),
		.ops(ops));
	// ==========================================
	// expected increments of one record
	function automatic voei_pkg::voei_inc_t exp_op(voei_pkg::voei_op_t o);
		voei_pkg::voei_inc_t e;
		logic [15:0] fx, q, n;
		e = '0;
		fx = o.vector ? 16'(o.elements) : 16'h0001;
		q = (o.cont_bits == 8'h00) ? 16'h0000 : 16'(128 / o.cont_bits);
		n = 16'h0000;
		if (!o.valid) return e;
		if (o.op_class == voei_pkg::VOEI_FLOAT && o.scalable) begin
			if (o.prec == voei_pkg::VOEI_PREC_HALF) e.scalable_half_float_ops = 16'h0008 << o.fused;
			if (o.prec == voei_pkg::VOEI_PREC_SINGLE) e.scalable_single_float_ops = 16'h0004 << o.fused;
			if (o.prec == voei_pkg::VOEI_PREC_DOUBLE) e.scalable_double_float_ops = 16'h0002 << o.fused;
		end else if (o.op_class == voei_pkg::VOEI_FLOAT) begin
			e.fixed_float_element_ops = fx << o.fused;
			if (o.prec == voei_pkg::VOEI_PREC_HALF) e.fixed_half_float_ops = fx << o.fused;
			if (o.prec == voei_pkg::VOEI_PREC_SINGLE) e.fixed_single_float_ops = fx << o.fused;
			if (o.prec == voei_pkg::VOEI_PREC_DOUBLE)
				e.fixed_double_float_ops = (o.vector ? 16'h0002 : 16'h0001) << o.fused;
		end else if (o.op_class == voei_pkg::VOEI_INT) begin
			if (o.scalable) e.scalable_integer_ops = q << o.fused;
			else e.fixed_integer_ops = fx << o.fused;
		end else if (o.op_class == voei_pkg::VOEI_MEM && o.scalable
			&& o.access == voei_pkg::VOEI_ACC_VECTOR) begin
			q = q * 16'(o.regs);
			e.scalable_memory_access_ops = q;
			e.scalable_read_ops = o.is_load ? q : 16'h0000;
			e.scalable_write_ops = o.is_store ? q : 16'h0000;
			if (o.mem_bits != 8'h00 && o.mem_bits <= o.cont_bits)
				e.scalable_memory_byte_count = 16'(16 / (o.cont_bits / o.mem_bits)) * 16'(o.regs);
		end else if (o.op_class == voei_pkg::VOEI_MEM) begin
			case (o.access)
				voei_pkg::VOEI_ACC_PAIR: n = 16'h0002;
				voei_pkg::VOEI_ACC_REPL_QUAD: n = q;
				voei_pkg::VOEI_ACC_STRUCT: n = 16'(o.elements) * 16'(o.regs);
				voei_pkg::VOEI_ACC_VECTOR: n = 16'h0000;
				default: n = 16'h0001;
			endcase
			e.fixed_memory_access_ops = (o.access == voei_pkg::VOEI_ACC_ATOMIC && o.is_load) ?
				16'h0002 : n;
			e.fixed_read_ops = o.is_load ? n : 16'h0000;
			e.fixed_write_ops = o.is_store ? n : 16'h0000;
		end
		return e;
	endfunction : exp_op
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop
	// directed record on the first k lanes, then three idle cycles
	task automatic apply(input string nm, input int k);
		for (int i = 0; i < LANES; i++) pick[i] <= (i < k) ? o : '0;
		@(negedge clk) pick <= '0;
		repeat (3) @(negedge clk);
		$display("test %s done", nm);
	endtask : apply
	// ==========================================
	// reference sum of all lanes, then compare every field
	always @(posedge clk) begin
		exp_q = '0;
		for (int l = 0; l < LANES; l++) begin
			lane_exp = exp_op(ops[l]);
			for (int f = 0; f < 16; f++) exp_q[f*16 +: 16] += lane_exp[f*16 +: 16];
		end
		if (!rst_b) exp_q = '0;
	end
	always @(negedge clk) begin
		if (chk_en) for (int f = 0; f < 16; f++)
			check($sformatf("field %0d", f), inc_ff[f*16 +: 16], exp_q[f*16 +: 16]);
	end
	initial begin
		#2000000;
		miscompares++;
		report_and_stop();
	end
	// ==========================================
	// main sequence: reset, corner records, random traffic, reset in mid-run
	initial begin
		#1 rst_b = 1'b0; // a real falling edge clears the outputs before the first clock
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		chk_en = 1'b1;
		o = '0;
		{o.valid, o.op_class, o.scalable, o.fused, o.prec} = {5'h17, voei_pkg::VOEI_PREC_HALF};
		apply("scalable fused half", 1);
		{o.scalable, o.vector, o.elements, o.prec} = {2'h1, 8'h07, voei_pkg::VOEI_PREC_DOUBLE};
		apply("fixed double vector", 1);
		{o.op_class, o.scalable, o.cont_bits} = {voei_pkg::VOEI_INT, 1'b1, 8'h00};
		apply("integer zero container", 1);
		{o.op_class, o.access, o.cont_bits, o.mem_bits, o.regs, o.is_store} =
			{voei_pkg::VOEI_MEM, voei_pkg::VOEI_ACC_VECTOR, 16'h4008, 4'h9};
		apply("scalable store", 1);
		{o.scalable, o.access, o.is_load, o.is_store} = {1'b0, voei_pkg::VOEI_ACC_ATOMIC, 2'h2};
		apply("atomic read all lanes", LANES);
		{o.scalable, o.access, o.cont_bits} = {1'b1, voei_pkg::VOEI_ACC_REPL_QUAD, 8'h08};
		apply("replicate quadword", 1);
		rnd <= 1'b1;
		repeat (3000) @(negedge clk);
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		repeat (1000) @(negedge clk);
		$display("test random traffic done");
		report_and_stop();
	end
endmodule : vector_op_event_increment_tb
